// [logic/rspi_port.sv]
// radio serial slave port: command/address decode, burst access, pin muxing
// Functional notes
// - three-wire: one shared pin, both directions
// - interrupt on data pin only while deselected
// - four-wire: in on mosi, out on miso
// - select active low; traffic ignored otherwise
// - master alone drives serial clock
// - command byte then one or more data
// - bit7 direction, bit6 increment, bits5:0 address
// - direction 0 read, 1 write
// - increment set: address steps each byte
// - increment clear: same address, files step
// - port works without radio oscillator
// - miso and irq pins usable as gpio
// - forced end to sleep within 35us
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
module rspi_port import rspi_pkg::*; (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // serial link pins
   input wire logic sck_in,
   input wire logic ss_n_in,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_out,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_out,
   input wire logic irq_in,
   output logic irq_out,
   output logic irq_oe_out,
   // radio core side
   input wire logic irq_req_in,
   output logic sleep_req_out,
   // local register bus
   input wire logic [5:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out
);
   rspi_pins_t pins_raw;
   rspi_pins_t pins_s;
   rspi_state_t state;
   rspi_cmd_t cmd;
   logic sck_prev;
   logic rise_evt;
   logic fall_evt;
   logic ss_active;
   logic [2:0] bit_cnt;
   logic [7:0] rx_shift;
   logic [7:0] next_rx;
   logic [7:0] tx_shift;
   logic [3:0] file_idx;
   logic byte_done;
   logic rd_req;
   logic load_pend;
   logic spi_we;
   logic [5:0] spi_addr;
   logic [7:0] mem_a_q;
   logic [7:0] mem_b_q;
   logic [7:0] link_cfg;
   logic [7:0] gpio_ctrl;
   logic [7:0] xact_cfg;
   logic [7:0] bus_local_q;
   logic bus_local_sel;
   logic [7:0] spi_local_q;
   logic spi_local_sel;
   logic irq_q;
   logic sleep_armed;
   logic [9:0] quiet_cnt;
   logic sleep_fire;
   logic read_phase;
   logic tx_drive;

   // register address of the current byte, stepping inside the file
   function automatic logic [5:0] eff_addr(input rspi_cmd_t c, input logic [3:0] idx);
      eff_addr = (!c.inc && c.addr == FILE_BASE) ? 6'(FILE_BASE + {2'b00, idx}) : c.addr;
   endfunction : eff_addr

   function automatic logic is_local(input logic [5:0] a);
      is_local = (a == ADDR_LINK_CFG) || (a == ADDR_GPIO_CTRL) || (a == ADDR_XACT_CFG);
   endfunction : is_local

   function automatic logic [7:0] read_local(input logic [5:0] a, input logic [7:0] cfg,
                                             input logic [7:0] gp, input logic [7:0] xc,
                                             input logic [1:0] lvl);
      if (a == ADDR_LINK_CFG) read_local = cfg;
      else if (a == ADDR_GPIO_CTRL) read_local = {lvl, gp[5:0]};
      else read_local = xc;
   endfunction : read_local

   function automatic logic sleep_write(input logic [7:0] d);
      sleep_write = d[XACT_FORCE_BIT] && d[XACT_END_LSB +: 3] == END_SLEEP;
   endfunction : sleep_write

   // all link pins cross in through the filter, the serial clock included
   assign pins_raw = '{sck: sck_in, ss_n: ss_n_in, mosi: mosi_in, miso: miso_in, irq: irq_in};

   rspi_sync #(.W(5), .RST_VAL(PINS_RESET)) u_sync (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .raw_in(pins_raw),
      .level_out(pins_s)
   );

   // serial clock edges, never driven back out
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) sck_prev <= 1'b0;
      else sck_prev <= pins_s.sck;
   end

   assign rise_evt = pins_s.sck & ~sck_prev;
   assign fall_evt = ~pins_s.sck & sck_prev;
   assign ss_active = ~pins_s.ss_n;
   assign byte_done = rise_evt && ss_active && bit_cnt == 3'h7;
   assign next_rx = {rx_shift[6:0], pins_s.mosi};
   assign spi_addr = eff_addr(cmd, file_idx);
   assign spi_we = byte_done && state == ST_DATA && cmd.dir;
   assign read_phase = state == ST_DATA && !cmd.dir;

   // transaction state: select low opens, select high drops everything
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= ST_IDLE;
      end else if (!ss_active) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: state <= ST_CMD;
            ST_CMD: if (byte_done) state <= ST_DATA;
            ST_DATA: state <= ST_DATA;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // receive shifter and bit count, msb first on rising edges
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bit_cnt <= 3'h0;
         rx_shift <= 8'h00;
      end else if (!ss_active) begin
         bit_cnt <= 3'h0;
      end else if (rise_evt) begin
         bit_cnt <= 3'(bit_cnt + 3'h1);
         rx_shift <= next_rx;
      end
   end

   // command capture and address stepping between data bytes
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cmd <= '0;
         file_idx <= 4'h0;
      end else if (byte_done && state == ST_CMD) begin
         cmd <= next_rx;
         file_idx <= 4'h0;
      end else if (byte_done && state == ST_DATA) begin
         if (cmd.inc) cmd.addr <= 6'(cmd.addr + 6'h01);
         else if (cmd.addr == FILE_BASE) file_idx <= 4'(file_idx + 4'h1);
      end
   end

   // read fetch one cycle after the byte ends, once the address has moved
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_req <= 1'b0;
         load_pend <= 1'b0;
      end else begin
         rd_req <= byte_done && (state == ST_CMD ? !next_rx[7] : !cmd.dir);
         if (!ss_active) load_pend <= 1'b0;
         else if (byte_done) load_pend <= state == ST_CMD ? !next_rx[7] : !cmd.dir;
         else if (fall_evt) load_pend <= 1'b0;
      end
   end

   // local register value for the serial read path
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         spi_local_q <= 8'h00;
         spi_local_sel <= 1'b0;
      end else if (rd_req) begin
         spi_local_q <= read_local(spi_addr, link_cfg, gpio_ctrl, xact_cfg,
                                   {pins_s.irq, pins_s.miso});
         spi_local_sel <= is_local(spi_addr);
      end
   end

   // transmit shifter: load or shift on falling edges
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_shift <= 8'h00;
      end else if (fall_evt && ss_active) begin
         if (load_pend) tx_shift <= spi_local_sel ? spi_local_q : mem_b_q;
         else tx_shift <= {tx_shift[6:0], 1'b0};
      end
   end

   // three-wire turnaround: drive only from the first read data fall,
   // so the master can still hold its last command bit through the high phase
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) tx_drive <= 1'b0;
      else if (!ss_active) tx_drive <= 1'b0;
      else if (fall_evt && load_pend && read_phase) tx_drive <= 1'b1;
   end

   rspi_regmem u_mem (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .a_addr_in(reg_addr_in),
      .a_wdata_in(reg_wdata_in),
      .a_we_in(reg_wr_in && !is_local(reg_addr_in)),
      .a_q_out(mem_a_q),
      .b_addr_in(spi_addr),
      .b_wdata_in(next_rx),
      .b_we_in(spi_we && !is_local(spi_addr)),
      .b_q_out(mem_b_q)
   );

   // control registers; serial writes override bus writes, sleep self-clear loses
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         link_cfg <= CFG_RESET;
         gpio_ctrl <= GPIO_RESET;
         xact_cfg <= XACT_RESET;
      end else begin
         if (sleep_fire) xact_cfg[XACT_FORCE_BIT] <= 1'b0;
         if (reg_wr_in && reg_addr_in == ADDR_LINK_CFG) link_cfg <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == ADDR_GPIO_CTRL) gpio_ctrl <= reg_wdata_in & GPIO_WR_MASK;
         if (reg_wr_in && reg_addr_in == ADDR_XACT_CFG) xact_cfg <= reg_wdata_in;
         if (spi_we && spi_addr == ADDR_LINK_CFG) link_cfg <= next_rx;
         if (spi_we && spi_addr == ADDR_GPIO_CTRL) gpio_ctrl <= next_rx & GPIO_WR_MASK;
         if (spi_we && spi_addr == ADDR_XACT_CFG) xact_cfg <= next_rx;
      end
   end

   // local bus read, data one cycle after the strobe
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bus_local_q <= 8'h00;
         bus_local_sel <= 1'b0;
      end else if (reg_rd_in) begin
         bus_local_q <= read_local(reg_addr_in, link_cfg, gpio_ctrl, xact_cfg,
                                   {pins_s.irq, pins_s.miso});
         bus_local_sel <= is_local(reg_addr_in);
      end
   end

   assign reg_rdata_out = bus_local_sel ? bus_local_q : mem_a_q;

   // sleep timer restarts at every rising serial clock edge
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sleep_armed <= 1'b0;
         quiet_cnt <= 10'h000;
      end else begin
         if ((spi_we && spi_addr == ADDR_XACT_CFG && sleep_write(next_rx)) ||
             (reg_wr_in && reg_addr_in == ADDR_XACT_CFG && sleep_write(reg_wdata_in)))
            sleep_armed <= 1'b1;
         else if (sleep_fire) sleep_armed <= 1'b0;
         if (rise_evt || !sleep_armed) quiet_cnt <= 10'h000;
         else quiet_cnt <= 10'(quiet_cnt + 10'h001);
      end
   end

   assign sleep_fire = sleep_armed && !rise_evt && quiet_cnt == SLEEP_CNT - 10'h001;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) sleep_req_out <= 1'b0;
      else sleep_req_out <= sleep_fire;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) irq_q <= 1'b0;
      else irq_q <= irq_req_in;
   end

   // shared data pin: read data in three-wire, interrupt while deselected
   always_comb begin
      mosi_oe_out = 1'b0;
      mosi_out = 1'b0;
      if (ss_active) begin
         mosi_oe_out = !link_cfg[CFG_FOUR_WIRE_BIT] && link_cfg[CFG_SWAP_BIT]
                       && read_phase && tx_drive;
         mosi_out = tx_shift[7];
      end else if (link_cfg[CFG_IRQ_MUX_BIT]) begin
         mosi_oe_out = 1'b1;
         mosi_out = irq_q;
      end
   end

   // miso pin: four-wire read data or gpio
   always_comb begin
      if (gpio_ctrl[GP_MISO_EN_BIT]) begin
         miso_oe_out = gpio_ctrl[GP_MISO_OE_BIT];
         miso_out = gpio_ctrl[GP_MISO_VAL_BIT];
      end else begin
         miso_oe_out = link_cfg[CFG_FOUR_WIRE_BIT] && ss_active;
         miso_out = tx_shift[7];
      end
   end

   // irq pin: interrupt request or gpio
   always_comb begin
      if (gpio_ctrl[GP_IRQ_EN_BIT]) begin
         irq_oe_out = gpio_ctrl[GP_IRQ_OE_BIT];
         irq_out = gpio_ctrl[GP_IRQ_VAL_BIT];
      end else begin
         irq_oe_out = 1'b1;
         irq_out = irq_q;
      end
   end

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   chk_irq_share: assert property (!ss_active && link_cfg[CFG_IRQ_MUX_BIT]
      |-> mosi_oe_out && mosi_out == irq_q) else $error("irq not on data pin");
   chk_irq_quiet: assert property (ss_active |-> !mosi_oe_out || (read_phase
      && link_cfg[CFG_SWAP_BIT])) else $error("data pin driven while selected");
   chk_four_wire: assert property (link_cfg[CFG_FOUR_WIRE_BIT] && ss_active
      && !gpio_ctrl[GP_MISO_EN_BIT] |-> miso_oe_out && !mosi_oe_out) else $error("bad 4-wire");
   chk_select_drop: assert property (!ss_active |=> state == ST_IDLE && bit_cnt == 3'h0)
      else $error("traffic kept while deselected");
   chk_cmd_fields: assert property (byte_done && state == ST_CMD |=> cmd.dir == $past(next_rx[7])
      && cmd.inc == $past(next_rx[6]) && cmd.addr == $past(next_rx[5:0]))
      else $error("command byte misdecoded");
   chk_inc_step: assert property (byte_done && state == ST_DATA && cmd.inc
      |=> cmd.addr == 6'($past(cmd.addr) + 6'h01)) else $error("no increment");
   chk_noinc_hold: assert property (byte_done && state == ST_DATA && !cmd.inc
      |=> cmd.addr == $past(cmd.addr)) else $error("address moved");
   chk_write_dir: assert property (spi_we |-> cmd.dir && state == ST_DATA)
      else $error("write outside write transfer");
   chk_msb_load: assert property (fall_evt && ss_active && load_pend
      |=> tx_shift == $past(spi_local_sel ? spi_local_q : mem_b_q)) else $error("bad load");
   chk_sleep_quiet: assert property (sleep_armed && rise_evt |=> !sleep_req_out [*8])
      else $error("sleep too early");
   chk_gpio_miso: assert property (gpio_ctrl[GP_MISO_EN_BIT] |-> miso_out
      == gpio_ctrl[GP_MISO_VAL_BIT]) else $error("miso gpio ignored");

   cov_write_burst: cover property (spi_we ##[1:200] spi_we);
   cov_read_burst: cover property (read_phase && load_pend ##[1:200] fall_evt);
   cov_sleep: cover property (sleep_req_out);
endmodule : rspi_port

// [logic/rspi_pkg.sv]
// constants, types and register map of the radio serial slave port
package rspi_pkg;

   // register map (6-bit register space)
   localparam logic [5:0] ADDR_LINK_CFG = 6'h3d;
   localparam logic [5:0] ADDR_GPIO_CTRL = 6'h3e;
   localparam logic [5:0] ADDR_XACT_CFG = 6'h0f;
   localparam logic [5:0] FILE_BASE = 6'h20;

   // serial_link_config fields
   localparam int CFG_SWAP_BIT = 7;
   localparam int CFG_IRQ_MUX_BIT = 1;
   localparam int CFG_FOUR_WIRE_BIT = 0;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // gpio control fields; bits 7:6 read back pin levels
   localparam int GP_MISO_EN_BIT = 0;
   localparam int GP_IRQ_EN_BIT = 1;
   localparam int GP_MISO_VAL_BIT = 2;
   localparam int GP_IRQ_VAL_BIT = 3;
   localparam int GP_MISO_OE_BIT = 4;
   localparam int GP_IRQ_OE_BIT = 5;
   localparam logic [7:0] GPIO_RESET = 8'h00;
   localparam logic [7:0] GPIO_WR_MASK = 8'h3f;

   // transaction_config fields
   localparam int XACT_FORCE_BIT = 5;
   localparam int XACT_END_LSB = 2;
   localparam logic [2:0] END_SLEEP = 3'h0;
   localparam logic [7:0] XACT_RESET = 8'h00;

   // sleep timing from the last rising serial clock edge
   localparam int CLK_HZ = 20_000_000;
   localparam int SLEEP_TIME_US = 35;
   localparam int SLEEP_CYC = (SLEEP_TIME_US * CLK_HZ) / 1_000_000;
   localparam int SYNC_LAT = 5;
   localparam logic [9:0] SLEEP_CNT = 10'(SLEEP_CYC - SYNC_LAT);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD = 2'b01,
      ST_DATA = 2'b10
   } rspi_state_t;

   // command/address byte
   typedef struct packed {
      logic dir;
      logic inc;
      logic [5:0] addr;
   } rspi_cmd_t;

   // link pins as sampled
   typedef struct packed {
      logic sck;
      logic ss_n;
      logic mosi;
      logic miso;
      logic irq;
   } rspi_pins_t;

   localparam rspi_pins_t PINS_RESET = '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0,
                                         miso: 1'b0, irq: 1'b0};

endpackage : rspi_pkg

// [logic/rspi_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module rspi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // raw and filtered levels
   input wire logic [W-1:0] raw_in,
   output logic [W-1:0] level_out
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // chain; only stage two and three are compared
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         level_out <= RST_VAL;
      end else begin
         s1 <= raw_in;
         s2 <= s1;
         s3 <= s2;
         level_out <= (level_out & ~(s2 ^~ s3)) | (s3 & (s2 ^~ s3));
      end
   end
endmodule : rspi_sync

// [logic/rspi_regmem.sv]
// 64 x 8 register storage, two ports, registered read data
`timescale 1ns/1ns
module rspi_regmem (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // port a: local register bus
   input wire logic [5:0] a_addr_in,
   input wire logic [7:0] a_wdata_in,
   input wire logic a_we_in,
   output logic [7:0] a_q_out,
   // port b: serial link
   input wire logic [5:0] b_addr_in,
   input wire logic [7:0] b_wdata_in,
   input wire logic b_we_in,
   output logic [7:0] b_q_out
);
   logic [7:0] mem [0:63];

   // storage; serial port wins a same-address collision
   always_ff @(posedge clk_in) begin
      if (a_we_in) begin
         mem[a_addr_in] <= a_wdata_in;
      end
      if (b_we_in) begin
         mem[b_addr_in] <= b_wdata_in;
      end
   end

   // registered read ports
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         a_q_out <= 8'h00;
         b_q_out <= 8'h00;
      end else begin
         a_q_out <= mem[a_addr_in];
         b_q_out <= mem[b_addr_in];
      end
   end
endmodule : rspi_regmem

// [verification/rspi_link_master.sv]
// serial master model driving the radio port link pins
`timescale 1ns/1ns
module rspi_link_master (
   // system clock
   input wire logic clk_in,
   // read data from the selected return pin
   input wire logic rx_in,
   // link pins driven by the master
   output logic sck_out,
   output logic ss_n_out,
   output logic mosi_out,
   output logic mosi_oe_out
);
   logic [7:0] tx_bytes [16];
   logic [7:0] rx_bytes [16];

   // idle link: clock low, deselected, data pin floated
   initial begin
      sck_out = 1'b0;
      ss_n_out = 1'b1;
      mosi_out = 1'b0;
      mosi_oe_out = 1'b0;
   end

   // one byte msb first; read bit taken late in the high phase, after the device shifted
   task automatic put_byte(input logic [7:0] b, input logic drive, output logic [7:0] got);
      for (int i = 7; i >= 0; i--) begin
         sck_out <= 1'b0;
         mosi_out <= b[i];
         mosi_oe_out <= drive;
         repeat (4) @(posedge clk_in);
         sck_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         got[i] = rx_in;
      end
      // extra high time so the device can fetch the next read byte
      repeat (4) @(posedge clk_in);
   endtask : put_byte

   // command byte then n data bytes; sel low leaves select high throughout
   task automatic frame(input logic [7:0] cmd, input int n, input logic sel);
      logic [7:0] unused;
      ss_n_out <= ~sel;
      repeat (4) @(posedge clk_in);
      put_byte(cmd, sel, unused);
      for (int k = 0; k < n; k++) begin
         put_byte(tx_bytes[k], cmd[7] & sel, rx_bytes[k]);
      end
      sck_out <= 1'b0;
      mosi_oe_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      ss_n_out <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask : frame
endmodule : rspi_link_master

// [verification/rspi_port_tb_top.sv]
// self-checking bench of the radio serial slave port
`timescale 1ns/1ns
module rspi_port_tb_top import rspi_pkg::*; ();
   localparam int SLEEP_LIMIT = 35 * 1000 / 50;
   // stimulus and bench state
   logic clk_in = 1'b0;
   logic flt = 1'b0;
   logic sleep_seen = 1'b0;
   logic resetn_in, irq_req, reg_wr, reg_rd, four, sck, ss_n, m_mosi, m_oe, sck_d;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, rd, reg_rdata;
   logic [7:0] mem [64];
   logic [15:0] lfsr = 16'h495f;
   logic mosi_out, mosi_oe, miso_out, miso_oe, irq_out, irq_oe, sleep_req;
   int bad_count, checks_done, since_rise, sleep_age;
   // an undriven pin toggles so a stale level never reads as valid
   wire mosi_pin = m_oe ? m_mosi : (mosi_oe ? mosi_out : flt);
   wire miso_pin = miso_oe ? miso_out : flt;
   wire irq_pin = irq_oe ? irq_out : flt;
   wire rx = four ? miso_pin : mosi_pin;

   rspi_port u_rspi_port (
      .clk_in(clk_in), .resetn_in(resetn_in), .sck_in(sck), .ss_n_in(ss_n),
      .mosi_in(mosi_pin), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe),
      .miso_in(miso_pin), .miso_out(miso_out), .miso_oe_out(miso_oe),
      .irq_in(irq_pin), .irq_out(irq_out), .irq_oe_out(irq_oe),
      .irq_req_in(irq_req), .sleep_req_out(sleep_req),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata)
   );

   rspi_link_master u_rspi_link_master (
      .clk_in(clk_in), .rx_in(rx), .sck_out(sck), .ss_n_out(ss_n),
      .mosi_out(m_mosi), .mosi_oe_out(m_oe)
   );

   // clock, floating-pin pattern and watchdog
   initial begin
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in) flt <= ~flt;
   initial begin
      #1_000_000;
      bad_count++;
      print_verdict();
   end

   // age of the last rising serial clock when the sleep pulse shows
   always @(posedge clk_in) begin
      sck_d <= sck;
      since_rise <= (sck & ~sck_d) ? 0 : since_rise + 1;
      if (sleep_req === 1'b1) begin
         sleep_seen <= 1'b1;
         sleep_age <= since_rise;
      end
   end

   // both ends driving the shared pin at once
   always @(negedge clk_in) begin
      if (m_oe === 1'b1 && mosi_oe === 1'b1) check("pin_clash", 8'h01, 8'h00);
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   // lfsr source of data bytes
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction : rnd

   // address of the k-th data byte of a burst
   function automatic logic [5:0] exp_addr(input logic [5:0] a, input logic inc, input int k);
      if (inc) return a + 6'(k);
      if (a == FILE_BASE) return FILE_BASE + 6'(k % 16);
      return a;
   endfunction : exp_addr

   // register bus cycles, entered and left at a rising edge
   task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      mem[a] = d;
      @(posedge clk_in);
      reg_wr <= 1'b0;
      @(posedge clk_in);
   endtask : bus_wr

   task automatic bus_rd(input logic [5:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_in);
      reg_rd <= 1'b0;
      @(negedge clk_in);
      d = reg_rdata;
      @(posedge clk_in);
   endtask : bus_rd

   task automatic bus_chk(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] got;
      bus_rd(a, got);
      check("reg_read", got, exp);
   endtask : bus_chk

   // serial frame with random data; writes update the expected map
   task automatic ser(input logic [7:0] cmd, input int n, input logic sel);
      for (int k = 0; k < n; k++) begin
         u_rspi_link_master.tx_bytes[k] = rnd();
         if (cmd[7] && sel) mem[exp_addr(cmd[5:0], cmd[6], k)] = u_rspi_link_master.tx_bytes[k];
      end
      u_rspi_link_master.frame(cmd, n, sel);
   endtask : ser

   task automatic ser_rd_chk(input logic [7:0] cmd, input int n);
      ser(cmd, n, 1'b1);
      for (int k = 0; k < n; k++) begin
         check("serial_read", u_rspi_link_master.rx_bytes[k], mem[exp_addr(cmd[5:0], cmd[6], k)]);
      end
   endtask : ser_rd_chk

   // main sequence
   initial begin
      resetn_in = 1'b0;
      irq_req = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
      four = 1'b0;
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      // reset values and plain storage written at both ends of the map, read back at address 00
      bus_chk(ADDR_LINK_CFG, CFG_RESET);
      bus_chk(ADDR_XACT_CFG, XACT_RESET);
      bus_wr(6'h00, rnd());
      bus_wr(6'h3f, rnd());
      bus_chk(6'h00, mem[0]);
      // four-wire increment bursts wrapping over the top address
      four <= 1'b1;
      bus_wr(ADDR_LINK_CFG, 8'h01);
      ser(8'hff, 4, 1'b1);
      bus_chk(6'h3f, mem[63]);
      bus_chk(6'h02, mem[2]);
      ser_rd_chk(8'h7f, 4);
      // no increment: plain register keeps the last byte, file steps
      ser(8'h90, 3, 1'b1);
      bus_chk(6'h10, mem[16]);
      ser(8'ha0, 3, 1'b1);
      bus_chk(6'h22, mem[34]);
      // traffic with select high is ignored
      bus_wr(6'h11, 8'h5a);
      ser(8'h91, 2, 1'b0);
      bus_chk(6'h11, 8'h5a);
      // three-wire: swap bit turns the shared pin for read data
      four <= 1'b0;
      bus_wr(ADDR_LINK_CFG, 8'h80);
      ser_rd_chk(8'h20, 3);
      ser(8'hc5, 2, 1'b1);
      bus_chk(6'h06, mem[6]);
      // interrupt on the data pin only while deselected
      bus_wr(ADDR_LINK_CFG, 8'h02);
      irq_req <= 1'b1;
      repeat (8) @(posedge clk_in);
      check("irq_pin", {4'h0, mosi_oe, mosi_out, irq_oe, irq_out}, 8'h0f);
      fork
         ser(8'h87, 1, 1'b1);
         begin
            repeat (20) @(posedge clk_in);
            check("irq_hidden", {7'h00, mosi_oe}, 8'h00);
         end
      join
      irq_req <= 1'b0;
      repeat (8) @(posedge clk_in);
      check("irq_pin", {4'h0, mosi_oe, mosi_out, irq_oe, irq_out}, 8'h0a);
      // return pins as general purpose outputs, levels read back
      bus_wr(ADDR_GPIO_CTRL, 8'h3f);
      repeat (8) @(posedge clk_in);
      check("gpio_out", {4'h0, miso_oe, miso_out, irq_oe, irq_out}, 8'h0f);
      bus_chk(ADDR_GPIO_CTRL, 8'hff);
      bus_wr(ADDR_GPIO_CTRL, 8'h03);
      repeat (8) @(posedge clk_in);
      bus_rd(ADDR_GPIO_CTRL, rd);
      check("gpio_off", {rd[5:0], miso_oe, irq_oe}, 8'h0c);
      bus_wr(ADDR_GPIO_CTRL, 8'h00);
      four <= 1'b1;
      bus_wr(ADDR_LINK_CFG, 8'h01);
      // forced end to sleep, timed from the last rising serial clock
      check("sleep_early", {7'h00, sleep_seen}, 8'h00);
      u_rspi_link_master.tx_bytes[0] = 8'h20;
      u_rspi_link_master.frame(8'h8f, 1, 1'b1);
      repeat (SLEEP_LIMIT) @(posedge clk_in);
      check("sleep_seen", {7'h00, sleep_seen}, 8'h01);
      check("sleep_late", {7'h00, sleep_age + 1 <= SLEEP_LIMIT}, 8'h01);
      bus_rd(ADDR_XACT_CFG, rd);
      check("force_clear", {7'h00, rd[XACT_FORCE_BIT]}, 8'h00);
      print_verdict();
   end
endmodule : rspi_port_tb_top
